// ==== verilog/adcc_top.sv ====
// Purpose: register file and sequencer of the converter control block
// Assumes: converter core returns data combinationally from its input
// Notes: one clock, divided by an enable pulse
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module adcc_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire adcc_pkg::adcc_bus_s bus,
  output logic [7:0] rdata,
  // converter core
  input wire logic [11:0] core_data,
  output logic core_reset,
  output logic core_power_down,
  output logic core_sample,
  output logic conv_clk_en,
  output logic [7:0] channel_onehot,
  output logic bandgap_routed,
  output logic bandgap_on,
  output logic ext_ref_sel,
  output logic vref_pin_digital_off,
  // system
  input wire logic low_voltage_reset_en,
  output logic conv_done_irq,
  // pins
  output logic [7:0] pin_analog,
  output logic [7:0] pin_pullup_allow
);
  adcc_pkg::adcc_state_s q_ff;
  adcc_pkg::adcc_state_s nxt_q;
  logic tick;
  logic [5:0] div_max;

  // ***********************************
  // clock divider
  // ***********************************
  function automatic logic [5:0] div_limit(input logic [2:0] code);
    // undefined code treated as the slowest rate rather than a stall
    if (code == adcc_pkg::CLK_DIV_UNDEF) begin
      div_limit = 6'h3f;
    end else begin
      div_limit = 6'((7'h01 << code) - 7'h01);
    end
  endfunction : div_limit

  always_comb begin
    div_max = div_limit(q_ff.clk_ref[2:0]);
    tick = (q_ff.div_cnt >= div_max);
  end

  // ***********************************
  // next state
  // ***********************************
  always_comb begin
    nxt_q = q_ff;
    nxt_q.irq = 1'b0;
    nxt_q.sample = 1'b0;
    nxt_q.rdata = 8'h00;
    nxt_q.div_cnt = tick ? 6'h00 : 6'(q_ff.div_cnt + 6'h01);
    if (bus.wr) begin
      case (bus.addr)
        adcc_pkg::ADDR_CONV_CTL: begin
          nxt_q.conv_ctl = (bus.wdata & adcc_pkg::CONV_CTL_MASK)
            & ~(8'h01 << adcc_pkg::BIT_BUSY) // busy flag is read-only
            | (q_ff.conv_ctl & (8'h01 << adcc_pkg::BIT_BUSY));
        end
        adcc_pkg::ADDR_CLK_REF: nxt_q.clk_ref =
          bus.wdata & adcc_pkg::CLK_REF_MASK;
        adcc_pkg::ADDR_PIN_EN: nxt_q.pin_en = bus.wdata;
        default: ;
      endcase
    end
    case (q_ff.st)
      adcc_pkg::ST_IDLE: begin
        if (nxt_q.conv_ctl[adcc_pkg::BIT_START]) begin
          nxt_q.st = adcc_pkg::ST_HELD;
        end
      end
      adcc_pkg::ST_HELD: begin
        // falling start launches the conversion
        if (!nxt_q.conv_ctl[adcc_pkg::BIT_START]) begin
          nxt_q.st = adcc_pkg::ST_CONV;
          nxt_q.tick_cnt = 5'h00;
        end
      end
      adcc_pkg::ST_CONV: begin
        if (nxt_q.conv_ctl[adcc_pkg::BIT_START]) begin
          nxt_q.st = adcc_pkg::ST_HELD;
        end else if (q_ff.conv_ctl[adcc_pkg::BIT_PDOWN]) begin
          nxt_q.st = adcc_pkg::ST_HELD;
        end else if (tick) begin
          if (q_ff.tick_cnt == adcc_pkg::CONV_TICKS - 5'h01) begin
            nxt_q.result = core_data;
            nxt_q.st = adcc_pkg::ST_IDLE;
            nxt_q.irq = 1'b1;
            nxt_q.sample = 1'b1;
          end else begin
            nxt_q.tick_cnt = 5'(q_ff.tick_cnt + 5'h01);
          end
        end
      end
      default: nxt_q.st = adcc_pkg::ST_IDLE;
    endcase
    // busy is one while held in reset or converting
    nxt_q.conv_ctl[adcc_pkg::BIT_BUSY] =
      (nxt_q.st != adcc_pkg::ST_IDLE);
    // an aborted held state stays busy until a new start completes
    if (q_ff.st == adcc_pkg::ST_HELD && nxt_q.st == adcc_pkg::ST_HELD) begin
      nxt_q.conv_ctl[adcc_pkg::BIT_BUSY] = 1'b1;
    end
    if (bus.rd) begin
      case (bus.addr)
        adcc_pkg::ADDR_RES_LO: nxt_q.rdata =
          q_ff.conv_ctl[adcc_pkg::BIT_JUSTIFY] ? q_ff.result[7:0]
          : {q_ff.result[3:0], 4'h0};
        adcc_pkg::ADDR_RES_HI: nxt_q.rdata =
          q_ff.conv_ctl[adcc_pkg::BIT_JUSTIFY]
          ? {4'h0, q_ff.result[11:8]}
          : q_ff.result[11:4];
        adcc_pkg::ADDR_CONV_CTL: nxt_q.rdata =
          q_ff.conv_ctl & adcc_pkg::CONV_CTL_MASK;
        adcc_pkg::ADDR_CLK_REF: nxt_q.rdata =
          q_ff.clk_ref & adcc_pkg::CLK_REF_MASK;
        adcc_pkg::ADDR_PIN_EN: nxt_q.rdata = q_ff.pin_en;
        default: nxt_q.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= '{st: adcc_pkg::ST_IDLE, conv_ctl: adcc_pkg::CONV_CTL_RST,
        clk_ref: adcc_pkg::CLK_REF_RST, pin_en: adcc_pkg::PIN_EN_RST,
        result: 12'h000, div_cnt: 6'h00, tick_cnt: 5'h00, rdata: 8'h00,
        irq: 1'b0, sample: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ***********************************
  // outputs
  // ***********************************
  always_comb begin
    rdata = q_ff.rdata;
    core_reset = (q_ff.st == adcc_pkg::ST_HELD);
    core_power_down = q_ff.conv_ctl[adcc_pkg::BIT_PDOWN];
    core_sample = q_ff.sample;
    conv_clk_en = tick;
    bandgap_routed = q_ff.clk_ref[adcc_pkg::BIT_ROUTE];
    channel_onehot = bandgap_routed ? 8'h00
      : (8'h01 << q_ff.conv_ctl[2:0]);
    bandgap_on = q_ff.clk_ref[adcc_pkg::BIT_BG_EN]
      | low_voltage_reset_en;
    ext_ref_sel = q_ff.clk_ref[adcc_pkg::BIT_REF];
    vref_pin_digital_off = ext_ref_sel;
    conv_done_irq = q_ff.irq;
    pin_analog = q_ff.pin_en;
    pin_pullup_allow = ~q_ff.pin_en;
  end

  // ***********************************
  // checks
  // ***********************************
  sequence s_start_pulse;
    q_ff.st == adcc_pkg::ST_HELD ##1 q_ff.st == adcc_pkg::ST_CONV;
  endsequence

  chk_start_launch: assert property (@(posedge clk) disable iff (!rst_n)
    s_start_pulse |-> q_ff.conv_ctl[adcc_pkg::BIT_BUSY])
    else $error("conversion launch without busy");
  chk_held_busy: assert property (@(posedge clk) disable iff (!rst_n)
    core_reset |-> q_ff.conv_ctl[adcc_pkg::BIT_BUSY])
    else $error("held reset without busy");
  chk_idle_busy: assert property (@(posedge clk) disable iff (!rst_n)
    (q_ff.st == adcc_pkg::ST_IDLE && $past(q_ff.st) == adcc_pkg::ST_IDLE
    && $past(rst_n)) |-> !q_ff.conv_ctl[adcc_pkg::BIT_BUSY])
    else $error("busy while idle");
  chk_done_irq: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(q_ff.conv_ctl[adcc_pkg::BIT_BUSY]) && !core_reset
    && $past(q_ff.st) == adcc_pkg::ST_CONV |-> conv_done_irq)
    else $error("busy cleared without interrupt");
  chk_result_upd: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done_irq |-> q_ff.result == $past(core_data))
    else $error("result not captured at end");
  chk_left_fmt: assert property (@(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == adcc_pkg::ADDR_RES_LO
    && !q_ff.conv_ctl[adcc_pkg::BIT_JUSTIFY]
    |=> rdata[3:0] == 4'h0)
    else $error("left format low nibble not zero");
  chk_right_fmt: assert property (@(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == adcc_pkg::ADDR_RES_HI
    && q_ff.conv_ctl[adcc_pkg::BIT_JUSTIFY]
    |=> rdata == {4'h0, $past(q_ff.result[11:8])})
    else $error("right format high byte wrong");
  chk_route_cut: assert property (@(posedge clk) disable iff (!rst_n)
    bandgap_routed |-> channel_onehot == 8'h00)
    else $error("channel connected while bandgap routed");
  chk_ctl_unimpl: assert property (@(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == adcc_pkg::ADDR_CLK_REF
    |=> rdata[5] == 1'b0 && rdata[3] == 1'b0)
    else $error("unimplemented bit reads one");
  chk_div_pace: assert property (@(posedge clk) disable iff (!rst_n)
    tick && q_ff.clk_ref[2:0] == 3'h1 && $stable(q_ff.clk_ref)
    |=> (!tick || q_ff.clk_ref[2:0] != 3'h1)
    ##1 (tick || q_ff.clk_ref[2:0] != 3'h1))
    else $error("divide by two pacing wrong");
  chk_pullup_off: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_analog & pin_pullup_allow) == 8'h00)
    else $error("pull-high on analog pin");

  // ***********************************
  // checks on register reads
  // ***********************************
  sequence s_read(logic [2:0] a);
    bus.rd && bus.addr == a;
  endsequence

  sequence s_write(logic [2:0] a);
    bus.wr && bus.addr == a;
  endsequence

  chk_left_hi: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_read(adcc_pkg::ADDR_RES_HI) ##0 !q_ff.conv_ctl[adcc_pkg::BIT_JUSTIFY]
    |=> rdata == $past(q_ff.result[11:4]))
    else $error("left format high byte wrong");

  chk_left_lo: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_read(adcc_pkg::ADDR_RES_LO) ##0 !q_ff.conv_ctl[adcc_pkg::BIT_JUSTIFY]
    |=> rdata[7:4] == $past(q_ff.result[3:0]))
    else $error("left format low byte wrong");

  chk_right_lo: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_read(adcc_pkg::ADDR_RES_LO) ##0 q_ff.conv_ctl[adcc_pkg::BIT_JUSTIFY]
    |=> rdata == $past(q_ff.result[7:0]))
    else $error("right format low byte wrong");

  chk_right_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_read(adcc_pkg::ADDR_RES_HI) ##0 q_ff.conv_ctl[adcc_pkg::BIT_JUSTIFY]
    |=> rdata[7:4] == 4'h0)
    else $error("right format unused bits not zero");

  chk_conv_unimpl: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_read(adcc_pkg::ADDR_CONV_CTL)
    |=> rdata[3] == 1'b0)
    else $error("unimplemented control bit reads one");

  chk_busy_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_read(adcc_pkg::ADDR_CONV_CTL)
    |=> rdata[6] == $past(q_ff.conv_ctl[adcc_pkg::BIT_BUSY]))
    else $error("busy flag read wrong");

  // ***********************************
  // checks on conversion and controls
  // ***********************************
  chk_start_held: assert property (
    @(posedge clk) disable iff (!rst_n)
    q_ff.conv_ctl[adcc_pkg::BIT_START]
    |-> q_ff.st == adcc_pkg::ST_HELD)
    else $error("start high without converter reset");

  chk_start_busy: assert property (
    @(posedge clk) disable iff (!rst_n)
    q_ff.conv_ctl[adcc_pkg::BIT_START]
    |-> q_ff.conv_ctl[adcc_pkg::BIT_BUSY])
    else $error("start high without busy");

  chk_end_idle: assert property (
    @(posedge clk) disable iff (!rst_n)
    conv_done_irq
    |-> q_ff.st == adcc_pkg::ST_IDLE && !q_ff.conv_ctl[adcc_pkg::BIT_BUSY])
    else $error("interrupt while still busy");

  chk_irq_pulse: assert property (
    @(posedge clk) disable iff (!rst_n)
    conv_done_irq
    |=> !conv_done_irq)
    else $error("interrupt longer than one cycle");

  chk_irq_source: assert property (
    @(posedge clk) disable iff (!rst_n)
    conv_done_irq
    |-> $past(q_ff.st) == adcc_pkg::ST_CONV)
    else $error("interrupt without conversion");

  chk_sample_irq: assert property (
    @(posedge clk) disable iff (!rst_n)
    conv_done_irq
    |-> core_sample)
    else $error("sample pulse missing at end");

  chk_result_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    !conv_done_irq
    |-> $stable(q_ff.result))
    else $error("result changed outside conversion end");

  chk_pdown_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_write(adcc_pkg::ADDR_CONV_CTL)
    |=> core_power_down == $past(bus.wdata[adcc_pkg::BIT_PDOWN]))
    else $error("power-down output wrong");

  chk_channel_sel: assert property (
    @(posedge clk) disable iff (!rst_n)
    !bandgap_routed
    |-> $onehot(channel_onehot) && channel_onehot[q_ff.conv_ctl[2:0]])
    else $error("wrong channel connected");

  chk_route_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_write(adcc_pkg::ADDR_CLK_REF)
    |=> bandgap_routed == $past(bus.wdata[adcc_pkg::BIT_ROUTE]))
    else $error("bandgap route output wrong");

  chk_bg_auto_off: assert property (
    @(posedge clk) disable iff (!rst_n)
    !q_ff.clk_ref[adcc_pkg::BIT_BG_EN] && !low_voltage_reset_en
    |-> !bandgap_on)
    else $error("bandgap left on while unused");

  chk_bg_lvr: assert property (
    @(posedge clk) disable iff (!rst_n)
    low_voltage_reset_en
    |-> bandgap_on)
    else $error("bandgap off while low-voltage reset on");

  chk_ref_pin: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_write(adcc_pkg::ADDR_CLK_REF)
    |=> ext_ref_sel == $past(bus.wdata[adcc_pkg::BIT_REF])
    && vref_pin_digital_off == ext_ref_sel)
    else $error("reference select outputs wrong");

  chk_div_one: assert property (
    @(posedge clk) disable iff (!rst_n)
    q_ff.clk_ref[2:0] == 3'h0 && $past(q_ff.clk_ref[2:0]) == 3'h0
    |-> tick)
    else $error("undivided clock enable missing");

  chk_pin_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_write(adcc_pkg::ADDR_PIN_EN)
    |=> pin_analog == $past(bus.wdata))
    else $error("analog pin select wrong");
endmodule : adcc_top
`default_nettype wire

// ==== verilog/adcc_pkg.sv ====
// Purpose: constants and types for the converter control block
// Assumes: 8-bit register port, 50 MHz clock
// Notes: register indices chosen locally
package adcc_pkg;
  localparam logic [2:0] ADDR_RES_LO = 3'h0;
  localparam logic [2:0] ADDR_RES_HI = 3'h1;
  localparam logic [2:0] ADDR_CONV_CTL = 3'h2;
  localparam logic [2:0] ADDR_CLK_REF = 3'h3;
  localparam logic [2:0] ADDR_PIN_EN = 3'h4;
  localparam int BIT_START = 7;
  localparam int BIT_BUSY = 6;
  localparam int BIT_PDOWN = 5;
  localparam int BIT_JUSTIFY = 4;
  localparam int BIT_ROUTE = 7;
  localparam int BIT_BG_EN = 6;
  localparam int BIT_REF = 4;
  localparam logic [7:0] CONV_CTL_MASK = 8'hf7;
  localparam logic [7:0] CLK_REF_MASK = 8'hd7;
  localparam logic [7:0] CONV_CTL_RST = 8'h60;
  localparam logic [7:0] CLK_REF_RST = 8'h00;
  localparam logic [7:0] PIN_EN_RST = 8'hff;
  // conversion length in converter clock periods
  localparam logic [4:0] CONV_TICKS = 5'h10;
  localparam logic [2:0] CLK_DIV_UNDEF = 3'h7;
  typedef enum logic [1:0] {ST_IDLE, ST_HELD, ST_CONV} adcc_state_e;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adcc_bus_s;
  typedef struct packed {
    adcc_state_e st;
    logic [7:0] conv_ctl;
    logic [7:0] clk_ref;
    logic [7:0] pin_en;
    logic [11:0] result;
    logic [5:0] div_cnt;
    logic [4:0] tick_cnt;
    logic [7:0] rdata;
    logic irq;
    logic sample;
  } adcc_state_s;
endpackage : adcc_pkg

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench for the converter control block
// Assumes: design assertions run alongside; converter data held steady
// Notes: all requests go through one-cycle strobe tasks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst_n, lvr_en;
  adcc_pkg::adcc_bus_s bus;
  logic [7:0] rdata, onehot, pin_an, pin_pu;
  logic [11:0] core_data, d;
  logic c_rst, c_pd, c_smp, clk_en, bg_rt, bg_on, ext_ref, vref_off, irq;
  logic [7:0] v, cc;
  logic [2:0] kk;
  int mismatches, checks_done, cycles, gap_cnt, last_gap, n;
  adcc_top i_adcc_top (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .core_data(core_data), .core_reset(c_rst), .core_power_down(c_pd),
    .core_sample(c_smp), .conv_clk_en(clk_en), .channel_onehot(onehot),
    .bandgap_routed(bg_rt), .bandgap_on(bg_on), .ext_ref_sel(ext_ref),
    .vref_pin_digital_off(vref_off), .low_voltage_reset_en(lvr_en),
    .conv_done_irq(irq), .pin_analog(pin_an), .pin_pullup_allow(pin_pu));
  // ****************
  // clock and watch
  // ****************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // gap between divider pulses, kept from the last pulse seen
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (clk_en === 1'b1) begin
      last_gap <= gap_cnt + 1;
      gap_cnt <= 0;
    end else gap_cnt <= gap_cnt + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      end_sim();
    end
  end
  // ****************
  // tasks
  // ****************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] wd);
    @(posedge clk);
    bus <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
  endtask : wr
  task automatic rchk(input string nm, input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    chk(nm, {4'h0, e}, {4'h0, rdata});
  endtask : rchk
  // ****************
  // tests
  // ****************
  initial begin
    rst_n = 1'b0; bus = '0; core_data = 12'h000; lvr_en = 1'b0;
    mismatches = 0; checks_done = 0; cycles = 0; gap_cnt = 0; last_gap = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rchk("conv_ctl reset", adcc_pkg::ADDR_CONV_CTL, 8'h20);
    rchk("clk_ref reset", adcc_pkg::ADDR_CLK_REF, 8'h00);
    rchk("pin_en reset", adcc_pkg::ADDR_PIN_EN, 8'hff);
    chk("power down", 12'h1, {11'h0, c_pd});
    wr(adcc_pkg::ADDR_RES_LO, 8'hff);
    wr(3'h5, 8'hff);
    rchk("result lo ro", adcc_pkg::ADDR_RES_LO, 8'h00);
    rchk("unmapped", 3'h5, 8'h00);
    $display("test reset and access done");
    for (int k = 0; k < 8; k++) begin
      wr(adcc_pkg::ADDR_CONV_CTL, 8'h20 | 8'(k));
      chk("channel", {4'h0, 8'(1 << k)}, {4'h0, onehot});
    end
    wr(adcc_pkg::ADDR_CONV_CTL, 8'h7f);
    rchk("conv_ctl unimpl", adcc_pkg::ADDR_CONV_CTL, 8'h37);
    wr(adcc_pkg::ADDR_CLK_REF, 8'h40);
    repeat (8) @(posedge clk);
    wr(adcc_pkg::ADDR_CLK_REF, 8'hff);
    rchk("clk_ref unimpl", adcc_pkg::ADDR_CLK_REF, 8'hd7);
    chk("routed cut", 12'h0, {4'h0, onehot});
    chk("routed", 12'h1, {11'h0, bg_rt});
    chk("ext ref", 12'h3, {10'h0, ext_ref, vref_off});
    wr(adcc_pkg::ADDR_CLK_REF, 8'h00);
    chk("bg off", 12'h0, {10'h0, bg_on, ext_ref});
    @(posedge clk) lvr_en <= 1'b1;
    @(negedge clk) chk("bg lvr", 12'h1, {11'h0, bg_on});
    @(posedge clk) lvr_en <= 1'b0;
    wr(adcc_pkg::ADDR_PIN_EN, 8'h5a);
    chk("pins", 12'h5a, {4'h0, pin_an});
    chk("pullups", 12'ha5, {4'h0, pin_pu});
    $display("test static controls done");
    for (int k = 0; k < 7; k++) begin
      kk = 3'(k);
      d = 12'h9c3 ^ {kk, kk, kk, kk};
      @(posedge clk) core_data <= d;
      wr(adcc_pkg::ADDR_CLK_REF, {5'h0, kk});
      cc = {3'b000, kk[0], 4'h2};
      wr(adcc_pkg::ADDR_CONV_CTL, cc | 8'h80);
      chk("core reset", 12'h1, {11'h0, c_rst});
      rchk("busy held", adcc_pkg::ADDR_CONV_CTL, cc | 8'hc0);
      wr(adcc_pkg::ADDR_CONV_CTL, cc);
      rchk("busy run", adcc_pkg::ADDR_CONV_CTL, cc | 8'h40);
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
        @(negedge clk);
        n++;
      end
      chk("irq", 12'h1, {11'h0, irq});
      @(negedge clk) chk("irq pulse", 12'h0, {11'h0, irq});
      chk("tick gap", 12'(1 << k), 12'(last_gap));
      rchk("busy done", adcc_pkg::ADDR_CONV_CTL, cc);
      rchk("res lo", adcc_pkg::ADDR_RES_LO,
        kk[0] ? d[7:0] : {d[3:0], 4'h0});
      rchk("res hi", adcc_pkg::ADDR_RES_HI,
        kk[0] ? {4'h0, d[11:8]} : d[11:4]);
    end
    wr(adcc_pkg::ADDR_CONV_CTL, 8'h20);
    chk("power down end", 12'h1, {11'h0, c_pd});
    $display("test conversions done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
